/* File: verilog/slcp_pkg.sv */
package slcp_pkg;
    // ==========================================================
    // local config port addressing
    localparam logic [5:0] I2C_DEV_BASE   = 6'h1D;   // arbitrary value
    localparam int         BYTE_BITS      = 8;
    localparam logic [3:0] BIT_LAST       = 4'h7;
    localparam logic [3:0] BIT_DONE       = 4'h8;

    // ==========================================================
    // register pointers
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h01;
    localparam logic [7:0] REG_INT_STAT   = 8'h02;
    localparam logic [7:0] REG_INT_MASK   = 8'h03;

    // ==========================================================
    // control fields
    localparam int         CTRL_SENSE_SEL = 0;
    localparam int         CTRL_CEC_DRV   = 1;       // bits 1 and 2
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] MASK_RST       = 8'h00;

    // ==========================================================
    // status and event fields
    localparam int         ST_TMDS_CLK    = 0;
    localparam int         ST_STRAP       = 1;
    localparam int         ST_TX_PWR      = 2;
    localparam int         ST_CEC_LVL     = 4;       // bits 4 and 5
    localparam int         EV_TMDS_CHG    = 0;
    localparam int         EV_CEC_FALL    = 1;       // bits 1 and 2
    localparam int         EV_W           = 3;

    // ==========================================================
    // pin synchroniser lanes
    localparam int         PIN_W          = 5;
    localparam int         PIN_STRAP      = 0;
    localparam int         PIN_SCL        = 1;
    localparam int         PIN_SDA        = 2;
    localparam int         PIN_CEC        = 3;       // lanes 3 and 4
    localparam int         CEC_N          = 2;

    // ==========================================================
    // slave states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_WR   = 3'h2,
        ST_WACK = 3'h6,
        ST_RD   = 3'h7,
        ST_RACK = 3'h5
    } slcp_state_t;
endpackage

/* File: verilog/slcp_i2c_slave.sv */
`timescale 1ns/1ps
module slcp_i2c_slave (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    // filtered bus levels
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [6:0] dev_addr_i,
    output logic            sda_low_o,
    // register access
    output logic [7:0]      reg_ptr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_wr_o,
    input  wire logic [7:0] reg_rdata_i
);
    slcp_pkg::slcp_state_t state_r;
    logic       scl_q_r;
    logic       sda_q_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic       rw_r;
    logic       first_r;
    logic       ack_r;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;

    assign rise  = scl_i & ~scl_q_r;
    assign fall  = ~scl_i & scl_q_r;
    assign start = scl_i & scl_q_r & sda_q_r & ~sda_i;
    assign stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;

    always_ff @(posedge clk_sys_i) begin
        scl_q_r <= scl_i;
        sda_q_r <= sda_i;
    end

    // ==========================================================
    // byte engine, pointer then auto-increment data
    always_ff @(posedge clk_sys_i) begin
        reg_wr_o <= 1'b0;
        if (!rst_n_i) begin
            state_r     <= slcp_pkg::ST_IDLE;
            cnt_r       <= 4'h0;
            sh_r        <= 8'h00;
            rw_r        <= 1'b0;
            first_r     <= 1'b0;
            ack_r       <= 1'b0;
            reg_ptr_o   <= 8'h00;
            reg_wdata_o <= 8'h00;
        end else if (start) begin
            state_r <= slcp_pkg::ST_ADDR;
            cnt_r   <= 4'h0;
            first_r <= 1'b1;
        end else if (stop) begin
            state_r <= slcp_pkg::ST_IDLE;
        end else begin
            case (state_r)
                slcp_pkg::ST_ADDR, slcp_pkg::ST_WR: begin
                    if (rise) begin
                        sh_r  <= {sh_r[6:0], sda_i};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (fall && cnt_r == slcp_pkg::BIT_DONE) begin
                        if (state_r == slcp_pkg::ST_ADDR) begin
                            rw_r    <= sh_r[0];
                            state_r <= (sh_r[7:1] == dev_addr_i) ? slcp_pkg::ST_AACK
                                                                 : slcp_pkg::ST_IDLE;
                        end else begin
                            state_r <= slcp_pkg::ST_WACK;
                            if (first_r) begin
                                reg_ptr_o <= sh_r;
                            end else begin
                                reg_wdata_o <= sh_r;
                                reg_wr_o    <= 1'b1;
                            end
                        end
                    end
                end
                slcp_pkg::ST_AACK: begin
                    if (fall) begin
                        cnt_r   <= 4'h0;
                        state_r <= rw_r ? slcp_pkg::ST_RD : slcp_pkg::ST_WR;
                        sh_r    <= reg_rdata_i;
                    end
                end
                slcp_pkg::ST_WACK: begin
                    if (fall) begin
                        cnt_r     <= 4'h0;
                        state_r   <= slcp_pkg::ST_WR;
                        first_r   <= 1'b0;
                        reg_ptr_o <= first_r ? reg_ptr_o : reg_ptr_o + 8'h01;
                    end
                end
                slcp_pkg::ST_RD: begin
                    if (fall) begin
                        sh_r  <= {sh_r[6:0], 1'b1};
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == slcp_pkg::BIT_LAST) begin
                            state_r   <= slcp_pkg::ST_RACK;
                            reg_ptr_o <= reg_ptr_o + 8'h01;
                        end
                    end
                end
                slcp_pkg::ST_RACK: begin
                    if (rise) begin
                        ack_r <= ~sda_i;
                    end else if (fall) begin
                        cnt_r   <= 4'h0;
                        sh_r    <= reg_rdata_i;
                        state_r <= ack_r ? slcp_pkg::ST_RD : slcp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= slcp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        case (state_r)
            slcp_pkg::ST_AACK, slcp_pkg::ST_WACK: sda_low_o = 1'b1;
            slcp_pkg::ST_RD:                      sda_low_o = ~sh_r[7];
            default:                              sda_low_o = 1'b0;
        endcase
    end
endmodule // slcp_i2c_slave

/* File: verilog/slcp_strap_latch_config_pins.sv */
`timescale 1ns/1ps
// Function
// - latch strap level at reset release as subaddress
// - strap pin input in reset, then drives
// - register selects tmds clock presence on output
// - external reset is active low
// - interrupt pin open drain, low when active
// - all registers reached over local config port
// - two independent controllers, one per line
module slcp_strap_latch_config_pins (
    // clock and reset
    input  wire logic            clk_sys_i,
    input  wire logic            rst_n_i,
    // strap and power sense pin
    input  wire logic            addr_strap_power_sense_pin_i,
    output logic                 addr_strap_power_sense_pin_o,
    output logic                 addr_strap_power_sense_pin_oe_o,
    output logic                 subaddr_sel_o,
    // sense sources
    input  wire logic            tx_power_sense_i,
    input  wire logic            rx_tmds_clk_det_i,
    // local config port pins
    input  wire logic            cfg_i2c_clk_i,
    input  wire logic            cfg_i2c_dat_i,
    output logic                 cfg_i2c_dat_o,
    output logic                 cfg_i2c_dat_oe_o,
    // line pins
    input  wire logic [1:0]      cec_line_i,
    output logic      [1:0]      cec_line_o,
    output logic      [1:0]      cec_line_oe_o,
    // interrupt pin
    output logic                 int_o,
    output logic                 int_oe_o
);
    // ==========================================================
    // decode helper
    function automatic logic hit(input logic [7:0] ptr, input logic [7:0] reg_ofs);
        hit = (ptr == reg_ofs);
    endfunction

    logic [slcp_pkg::PIN_W-1:0] pin_raw;
    logic [slcp_pkg::PIN_W-1:0] s1_r;
    logic [slcp_pkg::PIN_W-1:0] s2_r;
    logic [slcp_pkg::PIN_W-1:0] s3_r;
    logic [slcp_pkg::PIN_W-1:0] flt_r;
    logic                       strap_done_r;
    logic                       strap_r;
    logic                       tx_power_sense_out_r;
    logic [7:0]                 ctrl_r;
    logic [7:0]                 mask_r;
    logic [slcp_pkg::EV_W-1:0]  ev_stat_r;
    logic [slcp_pkg::EV_W-1:0]  ev_set;
    logic                       tmds_q_r;
    logic [1:0]                 cec_fall;
    logic [1:0]                 cec_oe_r;
    logic                       int_oe_r;
    logic                       sda_oe_r;
    logic                       sda_low;
    logic [7:0]                 reg_ptr;
    logic [7:0]                 reg_wdata;
    logic                       reg_wr;
    logic [7:0]                 reg_rdata;
    logic [7:0]                 status;

    assign pin_raw = {cec_line_i, cfg_i2c_dat_i, cfg_i2c_clk_i,
                      addr_strap_power_sense_pin_i};

    // ==========================================================
    // pin synchronisers, change taken once two stages agree
    genvar g;
    generate
        for (g = 0; g < slcp_pkg::PIN_W; g++) begin : g_sync
            always_ff @(posedge clk_sys_i) begin
                s1_r[g] <= pin_raw[g];
                s2_r[g] <= s1_r[g];
                s3_r[g] <= s2_r[g];
                if (s2_r[g] == s3_r[g]) begin
                    flt_r[g] <= s3_r[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // strap latch at reset release
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            strap_done_r <= 1'b0;
            strap_r      <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            strap_r      <= s3_r[slcp_pkg::PIN_STRAP];
        end
    end

    assign subaddr_sel_o = strap_r;

    // ==========================================================
    // power sense output on the strap pin
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tx_power_sense_out_r <= 1'b0;
        end else if (ctrl_r[slcp_pkg::CTRL_SENSE_SEL]) begin
            tx_power_sense_out_r <= rx_tmds_clk_det_i;
        end else begin
            tx_power_sense_out_r <= tx_power_sense_i;
        end
    end

    assign addr_strap_power_sense_pin_o    = tx_power_sense_out_r;
    assign addr_strap_power_sense_pin_oe_o = strap_done_r;

    // ==========================================================
    // line controllers, one per line
    generate
        for (g = 0; g < slcp_pkg::CEC_N; g++) begin : g_cec
            logic lvl_q_r;
            always_ff @(posedge clk_sys_i) begin
                if (!rst_n_i) begin
                    lvl_q_r     <= 1'b1;
                    cec_oe_r[g] <= 1'b0;
                end else begin
                    lvl_q_r     <= flt_r[slcp_pkg::PIN_CEC+g];
                    cec_oe_r[g] <= ctrl_r[slcp_pkg::CTRL_CEC_DRV+g];
                end
            end
            assign cec_fall[g] = lvl_q_r & ~flt_r[slcp_pkg::PIN_CEC+g];
        end
    endgenerate

    assign cec_line_o    = 2'h0;
    assign cec_line_oe_o = cec_oe_r;

    // ==========================================================
    // config port slave
    slcp_i2c_slave u_slave (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .scl_i       (flt_r[slcp_pkg::PIN_SCL]),
        .sda_i       (flt_r[slcp_pkg::PIN_SDA]),
        .dev_addr_i  ({slcp_pkg::I2C_DEV_BASE, strap_r}),
        .sda_low_o   (sda_low),
        .reg_ptr_o   (reg_ptr),
        .reg_wdata_o (reg_wdata),
        .reg_wr_o    (reg_wr),
        .reg_rdata_i (reg_rdata)
    );

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= sda_low;
        end
    end

    assign cfg_i2c_dat_o    = 1'b0;
    assign cfg_i2c_dat_oe_o = sda_oe_r;

    // ==========================================================
    // register file
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl_r <= slcp_pkg::CTRL_RST;
            mask_r <= slcp_pkg::MASK_RST;
        end else if (reg_wr) begin
            if (hit(reg_ptr, slcp_pkg::REG_CTRL)) begin
                ctrl_r <= reg_wdata;
            end
            if (hit(reg_ptr, slcp_pkg::REG_INT_MASK)) begin
                mask_r <= reg_wdata;
            end
        end
    end

    always_comb begin
        status                         = 8'h00;
        status[slcp_pkg::ST_TMDS_CLK]  = rx_tmds_clk_det_i;
        status[slcp_pkg::ST_STRAP]     = strap_r;
        status[slcp_pkg::ST_TX_PWR]    = tx_power_sense_i;
        status[slcp_pkg::ST_CEC_LVL]   = flt_r[slcp_pkg::PIN_CEC];
        status[slcp_pkg::ST_CEC_LVL+1] = flt_r[slcp_pkg::PIN_CEC+1];
    end

    always_comb begin
        if (hit(reg_ptr, slcp_pkg::REG_CTRL)) begin
            reg_rdata = ctrl_r;
        end else if (hit(reg_ptr, slcp_pkg::REG_STATUS)) begin
            reg_rdata = status;
        end else if (hit(reg_ptr, slcp_pkg::REG_INT_STAT)) begin
            reg_rdata = {5'h00, ev_stat_r};
        end else if (hit(reg_ptr, slcp_pkg::REG_INT_MASK)) begin
            reg_rdata = mask_r;
        end else begin
            reg_rdata = 8'h00;
        end
    end

    // ==========================================================
    // sticky events, set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tmds_q_r <= 1'b0;
        end else begin
            tmds_q_r <= rx_tmds_clk_det_i;
        end
    end

    assign ev_set = {cec_fall, tmds_q_r ^ rx_tmds_clk_det_i};

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ev_stat_r <= 3'h0;
        end else if (reg_wr && hit(reg_ptr, slcp_pkg::REG_INT_STAT)) begin
            ev_stat_r <= (ev_stat_r & ~reg_wdata[slcp_pkg::EV_W-1:0]) | ev_set;
        end else begin
            ev_stat_r <= ev_stat_r | ev_set;
        end
    end

    // ==========================================================
    // interrupt pin
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            int_oe_r <= 1'b0;
        end else begin
            int_oe_r <= |(ev_stat_r & mask_r[slcp_pkg::EV_W-1:0]);
        end
    end

    assign int_o    = 1'b0;
    assign int_oe_o = int_oe_r;
endmodule // slcp_strap_latch_config_pins

/* File: tb/slcp_chk.sv */
`timescale 1ns/1ps
// ==========================================================
// port checker
module slcp_chk (
    input wire logic       clk_sys_i, rst_n_i,
    input wire logic       addr_strap_power_sense_pin_i, addr_strap_power_sense_pin_o,
    input wire logic       addr_strap_power_sense_pin_oe_o, subaddr_sel_o,
    input wire logic       tx_power_sense_i, rx_tmds_clk_det_i,
    input wire logic       cfg_i2c_clk_i, cfg_i2c_dat_i, cfg_i2c_dat_o, cfg_i2c_dat_oe_o,
    input wire logic [1:0] cec_line_i, cec_line_o, cec_line_oe_o,
    input wire logic       int_o, int_oe_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=>
        !addr_strap_power_sense_pin_oe_o && !subaddr_sel_o && !cfg_i2c_dat_oe_o
        && !int_oe_o && cec_line_oe_o == 2'h0) else $error("output active in reset");
    a_pin_drive: assert property (disable iff (1'b0) $rose(rst_n_i) |=>
        addr_strap_power_sense_pin_oe_o) else $error("pin not driven after reset");
    a_strap_hold: assert property ($past(addr_strap_power_sense_pin_oe_o) |->
        $stable(subaddr_sel_o)) else $error("subaddress changed");
    a_sense_src: assert property (addr_strap_power_sense_pin_oe_o |->
        addr_strap_power_sense_pin_o == $past(tx_power_sense_i)
        || addr_strap_power_sense_pin_o == $past(rx_tmds_clk_det_i)) else $error("sense wrong");
    a_sda_stable: assert property (cfg_i2c_clk_i [*8] |-> $stable(cfg_i2c_dat_oe_o))
        else $error("data moved while clock high");
    a_int_od: assert property (int_o == 1'b0) else $error("interrupt pin driven high");
    a_sda_od: assert property (cfg_i2c_dat_o == 1'b0) else $error("data pin driven high");
    a_cec_od: assert property (cec_line_o == 2'h0) else $error("line driven high");
    c_int: cover property (int_oe_o);
    c_ack: cover property ($rose(cfg_i2c_dat_oe_o));
    c_cec: cover property (cec_line_oe_o != 2'h0);
endmodule // slcp_chk

bind slcp_strap_latch_config_pins slcp_chk chk_u (.*);

/* File: tb/slcp_i2c_host.sv */
`timescale 1ns/1ps
// ==========================================================
// config port host
module slcp_i2c_host #(
    parameter int HP = 16
) (
    input  wire logic clk_sys_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // one bit, line sampled mid high
    task automatic xfer(input logic b, output logic r);
        wt(4);
        sda_low_o = !b;
        wt(HP);
        scl_o = 1'b1;
        wt(HP / 2);
        r = sda_i;
        wt(HP / 2);
        scl_o = 1'b0;
    endtask
    task automatic start();
        wt(4);
        sda_low_o = 1'b0;
        wt(HP);
        scl_o = 1'b1;
        wt(HP);
        sda_low_o = 1'b1;
        wt(HP);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        wt(4);
        sda_low_o = 1'b1;
        wt(HP);
        scl_o = 1'b1;
        wt(HP);
        sda_low_o = 1'b0;
        wt(HP);
    endtask
    // byte msb first, ninth bit released
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r);
            q[i] = r;
        end
        xfer(1'b1, r);
        ack = !r;
    endtask
endmodule // slcp_i2c_host

/* File: tb/slcp_strap_latch_config_pins_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// bench top
module slcp_strap_latch_config_pins_tb;
    logic        clk_sys_i, rst_n_i, strap_lvl, tx_pwr, rx_clk, s;
    logic        pin_o, pin_oe, subaddr, dat_o, dat_oe, int_o, int_oe, scl, sda_low;
    logic [1:0]  cec_ext_low, cec_o, cec_oe;
    logic [15:0] seed;
    int          n_fail, num_checks;
    wire         pin_lvl = pin_oe ? pin_o : strap_lvl;
    wire         sda_lvl = !(sda_low || dat_oe);
    wire  [1:0]  cec_lvl = ~(cec_ext_low | cec_oe);
    slcp_strap_latch_config_pins dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .addr_strap_power_sense_pin_i(pin_lvl), .addr_strap_power_sense_pin_o(pin_o),
        .addr_strap_power_sense_pin_oe_o(pin_oe), .subaddr_sel_o(subaddr),
        .tx_power_sense_i(tx_pwr), .rx_tmds_clk_det_i(rx_clk), .cfg_i2c_clk_i(scl),
        .cfg_i2c_dat_i(sda_lvl), .cfg_i2c_dat_o(dat_o), .cfg_i2c_dat_oe_o(dat_oe),
        .cec_line_i(cec_lvl), .cec_line_o(cec_o), .cec_line_oe_o(cec_oe),
        .int_o(int_o), .int_oe_o(int_oe));
    slcp_i2c_host host_u (.clk_sys_i(clk_sys_i), .sda_i(sda_lvl), .scl_o(scl),
        .sda_low_o(sda_low));
    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic exp_sense(input logic [7:0] c, input logic t, input logic r);
        return c[slcp_pkg::CTRL_SENSE_SEL] ? r : t;
    endfunction
    function automatic logic [7:0] exp_status(input logic t, input logic r, input logic st,
                                              input logic [1:0] lv);
        logic [7:0] v;
        v = 8'h00;
        v[slcp_pkg::ST_TMDS_CLK] = r;
        v[slcp_pkg::ST_STRAP] = st;
        v[slcp_pkg::ST_TX_PWR] = t;
        v[slcp_pkg::ST_CEC_LVL +: 2] = lv;
        return v;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       k;
        host_u.start();
        host_u.byte_io({slcp_pkg::I2C_DEV_BASE, s, 1'b0}, q, k);
        chk(k, 8'h01);
        host_u.byte_io(a, q, k);
        host_u.byte_io(d, q, k);
        chk(k, 8'h01);
        host_u.stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic k;
        host_u.start();
        host_u.byte_io({slcp_pkg::I2C_DEV_BASE, s, 1'b0}, q, k);
        host_u.byte_io(a, q, k);
        host_u.start();
        host_u.byte_io({slcp_pkg::I2C_DEV_BASE, s, 1'b1}, q, k);
        chk(k, 8'h01);
        host_u.byte_io(8'hFF, q, k);
        host_u.stop();
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================================
    // clock, watchdog, sequence
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #400us;
        n_fail++;
        wrap_up();
    end
    initial begin
        logic [7:0] q;
        logic [7:0] c;
        logic       k;
        n_fail = 0;
        num_checks = 0;
        seed = 16'hCE52;
        rst_n_i = 1'b0;
        {strap_lvl, tx_pwr, rx_clk, s} = 4'h0;
        cec_ext_low = 2'h0;
        for (int si = 0; si < 2; si++) begin
            @(negedge clk_sys_i);
            rst_n_i = 1'b0;
            s = si[0];
            strap_lvl = s;
            repeat (10) @(negedge clk_sys_i);
            chk(pin_oe, 8'h00);
            rst_n_i = 1'b1;
            repeat (6) @(negedge clk_sys_i);
            chk(subaddr, s);
            chk(pin_oe, 8'h01);
            strap_lvl = !s;
            rd(slcp_pkg::REG_STATUS, q);
            chk(q[slcp_pkg::ST_STRAP], s);
            chk(q, exp_status(tx_pwr, rx_clk, s, cec_lvl));
            host_u.start();
            host_u.byte_io({slcp_pkg::I2C_DEV_BASE, !s, 1'b0}, q, k);
            host_u.stop();
            chk(k, 8'h00);
            rd(8'h10, q);
            chk(q, 8'h00);
            for (int i = 0; i < 6; i++) begin
                seed = lfsr(seed);
                c = {5'h00, seed[2:1], i[0]};
                wr(slcp_pkg::REG_CTRL, c);
                rd(slcp_pkg::REG_CTRL, q);
                chk(q, c);
                chk(cec_oe, c[2:1]);
                repeat (8) begin
                    seed = lfsr(seed);
                    {tx_pwr, rx_clk} = seed[1:0];
                    @(negedge clk_sys_i);
                    chk(pin_o, exp_sense(c, tx_pwr, rx_clk));
                end
            end
        end
        rx_clk = 1'b0;
        wr(slcp_pkg::REG_CTRL, 8'h00);
        wr(slcp_pkg::REG_INT_MASK, 8'h00);
        wr(slcp_pkg::REG_INT_STAT, 8'h07);
        cec_ext_low = 2'h1;
        repeat (20) @(negedge clk_sys_i);
        cec_ext_low = 2'h0;
        rd(slcp_pkg::REG_INT_STAT, q);
        chk(q, 8'h02);
        chk(int_oe, 8'h00);
        wr(slcp_pkg::REG_INT_MASK, 8'h02);
        chk(int_oe, 8'h01);
        chk(int_oe ? int_o : 1'b1, 8'h00);
        wr(slcp_pkg::REG_INT_STAT, 8'h02);
        chk(int_oe, 8'h00);
        cec_ext_low = 2'h2;
        rx_clk = 1'b1;
        rd(slcp_pkg::REG_STATUS, q);
        chk(q, exp_status(tx_pwr, rx_clk, s, cec_lvl));
        cec_ext_low = 2'h0;
        rd(slcp_pkg::REG_INT_STAT, q);
        chk(q, 8'h05);
        chk(int_oe, 8'h00);
        wrap_up();
    end
endmodule // slcp_strap_latch_config_pins_tb
